// ==== common/sar_adc_regs.vh ====
// Register map, field positions, reset values and timing counts of the converter controller.
// Assumes an 8-bit special-function-register bus with byte addresses.
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH

`define ADC_PRESCALE_ADDR     8'h94
`define ADC_RESULT_LOW_ADDR   8'h95
`define ADC_RESULT_HIGH_ADDR  8'h96
`define ADC_CONTROL_ADDR      8'h97

`define CTL_IRQ_FLAG_BIT      7
`define CTL_IRQ_EN_BIT        6
`define CTL_CONV_EN_BIT       5
`define CTL_CHAN_MSB          4
`define CTL_CHAN_LSB          2
`define CTL_START_BIT         1
`define CTL_DONE_BIT          0

`define PS_REFCLK_EN_BIT      3
`define PS_DIV_MSB            2
`define PS_DIV_LSB            0

`define ADC_CONTROL_RESET     8'h00
`define ADC_PRESCALE_RESET    8'h00
`define ADC_RESULT_RESET      8'h00

`define ADC_RESULT_BITS       10
`define ADC_CHANNELS          8
`define ADC_CAL_TIME_MS       16
`define ADC_CLK_HZ            50000000
`define ADC_CAL_CYCLES        ((`ADC_CAL_TIME_MS * `ADC_CLK_HZ) / 1000)

`endif

// ==== verilog/sar_adc_control.v ====
// Control and status logic of an eight-channel, 10-bit successive-approximation converter.
// Assumes a synchronous SFR bus (address, write strobe, write data, read strobe) and an analog
// comparator that answers the trial code shown on o_dac_code within the same clock cycle.
`include "sar_adc_regs.vh"
`default_nettype none

module sar_adc_control #(
	parameter integer CAL_CYCLES = `ADC_CAL_CYCLES
) (
	input  wire                         i_sys_clk,
	input  wire                         i_nrst,
	input  wire [7:0]                   i_sfr_addr,
	input  wire                         i_sfr_wr,
	input  wire [7:0]                   i_sfr_wdata,
	input  wire                         i_sfr_rd,
	input  wire [7:0]                   i_port1_func_select,
	input  wire [7:0]                   i_port1_alt_select,
	input  wire [7:0]                   i_port1_pins,
	input  wire                         i_cmp_high,
	output reg  [7:0]                   o_sfr_rdata,
	output reg                          o_conv_irq,
	output reg                          o_converter_power,
	output reg                          o_converter_refclk,
	output reg  [`ADC_RESULT_BITS-1:0]  o_dac_code,
	output reg                          o_analog_in,
	output reg                          o_calibrated,
	output reg  [7:0]                   o_port1_gpio_mode
);

	// ****************************************************************
	// Register state
	// ****************************************************************
	reg                         conv_irq_flag_ff;
	reg                         conv_irq_enable_ff;
	reg                         converter_enable_ff;
	reg  [2:0]                  channel_select_ff;
	reg                         conv_start_ff;
	reg                         conv_done_ff;
	reg                         refclk_enable_ff;
	reg  [2:0]                  refclk_div_ff;
	reg  [7:0]                  result_low_ff;
	reg  [1:0]                  result_high_ff;
	reg                         running_ff;
	reg                         busy_ff;
	reg  [3:0]                  bit_idx_ff;
	reg  [`ADC_RESULT_BITS-1:0] sar_ff;
	reg  [1:0]                  div_cnt_ff;
	reg  [31:0]                 cal_cnt_ff;

	// Index of the first trial bit, the result's top bit
	localparam [31:0] TOP_BIT = `ADC_RESULT_BITS - 1;

	// Strobe qualified by one register address
	function reg_hit;
		input       strobe;
		input [7:0] addr;
		input [7:0] target;
		begin
			reg_hit = strobe && (addr == target);
		end
	endfunction

	wire wr_ctl = reg_hit(i_sfr_wr, i_sfr_addr, `ADC_CONTROL_ADDR);
	wire wr_ps  = reg_hit(i_sfr_wr, i_sfr_addr, `ADC_PRESCALE_ADDR);

	// ****************************************************************
	// Reference clock enable
	// ****************************************************************
	reg ref_tick;
	always @* begin
		case (refclk_div_ff)
			3'h1:    ref_tick = (div_cnt_ff[0] == 1'b1);
			3'h2:    ref_tick = (div_cnt_ff == 2'h3);
			default: ref_tick = 1'b1;
		endcase
		ref_tick = ref_tick && refclk_enable_ff;
	end

	always @(posedge i_sys_clk) begin
		if (!i_nrst)
			div_cnt_ff <= 2'h0;
		else if (refclk_enable_ff)
			div_cnt_ff <= div_cnt_ff + 2'h1;
		else
			div_cnt_ff <= 2'h0;
	end

	// ****************************************************************
	// Successive approximation and control register
	// ****************************************************************
	wire can_run   = converter_enable_ff && refclk_enable_ff;
	wire step      = busy_ff && ref_tick;
	wire [`ADC_RESULT_BITS-1:0] trial_bit = {{(`ADC_RESULT_BITS-1){1'b0}}, 1'b1} << bit_idx_ff;
	wire [`ADC_RESULT_BITS-1:0] kept = i_cmp_high ? sar_ff : (sar_ff & ~trial_bit);
	wire last_step = step && (bit_idx_ff == 4'h0);
	wire launch    = running_ff && can_run && !busy_ff;

	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			conv_irq_flag_ff    <= 1'b0;
			conv_irq_enable_ff  <= 1'b0;
			converter_enable_ff <= 1'b0;
			channel_select_ff   <= 3'h0;
			conv_start_ff       <= 1'b0;
			conv_done_ff        <= 1'b0;
			refclk_enable_ff    <= 1'b0;
			refclk_div_ff       <= 3'h0;
			result_low_ff       <= 8'h00;
			result_high_ff      <= 2'h0;
			running_ff          <= 1'b0;
			busy_ff             <= 1'b0;
			bit_idx_ff          <= 4'h0;
			sar_ff              <= {`ADC_RESULT_BITS{1'b0}};
			o_dac_code          <= {`ADC_RESULT_BITS{1'b0}};
		end else begin
			if (wr_ps) begin
				refclk_enable_ff <= i_sfr_wdata[`PS_REFCLK_EN_BIT];
				refclk_div_ff    <= i_sfr_wdata[`PS_DIV_MSB:`PS_DIV_LSB];
			end
			// Start bit self-clears on the cycle after it is written
			conv_start_ff <= wr_ctl && i_sfr_wdata[`CTL_START_BIT];
			if (wr_ctl) begin
				conv_irq_enable_ff  <= i_sfr_wdata[`CTL_IRQ_EN_BIT];
				converter_enable_ff <= i_sfr_wdata[`CTL_CONV_EN_BIT];
				channel_select_ff   <= i_sfr_wdata[`CTL_CHAN_MSB:`CTL_CHAN_LSB];
			end
			if (!converter_enable_ff)
				running_ff <= 1'b0;
			else if (conv_start_ff)
				running_ff <= 1'b1;
			if (!can_run) begin
				busy_ff <= 1'b0;
			end else if (launch) begin
				busy_ff    <= 1'b1;
				bit_idx_ff <= TOP_BIT[3:0];
				// Trial code leaves in step with the SAR so the answer matches it
				sar_ff     <= {1'b1, {(`ADC_RESULT_BITS-1){1'b0}}};
				o_dac_code <= {1'b1, {(`ADC_RESULT_BITS-1){1'b0}}};
			end else if (step) begin
				if (last_step) begin
					busy_ff        <= 1'b0;
					result_low_ff  <= kept[7:0];
					result_high_ff <= kept[9:8];
				end else begin
					bit_idx_ff <= bit_idx_ff - 4'h1;
					sar_ff     <= kept | (trial_bit >> 1);
					o_dac_code <= kept | (trial_bit >> 1);
				end
			end
			// Completion sets; launch clears; software write of 0 to the done bit clears (set wins)
			if (last_step)
				conv_done_ff <= 1'b1;
			else if (launch || (wr_ctl && !i_sfr_wdata[`CTL_DONE_BIT]))
				conv_done_ff <= 1'b0;
			if (last_step && !conv_done_ff)
				conv_irq_flag_ff <= 1'b1;
			else if (wr_ctl && !i_sfr_wdata[`CTL_IRQ_FLAG_BIT])
				conv_irq_flag_ff <= 1'b0;
		end
	end

	// ****************************************************************
	// Calibration timer after converter enable
	// ****************************************************************
	always @(posedge i_sys_clk) begin
		if (!i_nrst)
			cal_cnt_ff <= 32'h0;
		else if (!converter_enable_ff)
			cal_cnt_ff <= 32'h0;
		else if (cal_cnt_ff < CAL_CYCLES)
			cal_cnt_ff <= cal_cnt_ff + 32'h1;
	end

	// ****************************************************************
	// Outputs and read data
	// ****************************************************************
	wire [7:0] ctl_view = {conv_irq_flag_ff, conv_irq_enable_ff, converter_enable_ff,
		channel_select_ff, conv_start_ff, conv_done_ff};
	wire [7:0] pin_to_adc = i_port1_func_select & i_port1_alt_select;

	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_sfr_rdata        <= 8'h00;
			o_conv_irq         <= 1'b0;
			o_converter_power  <= 1'b0;
			o_converter_refclk <= 1'b0;
			o_analog_in        <= 1'b0;
			o_calibrated       <= 1'b0;
			o_port1_gpio_mode  <= 8'hFF;
		end else begin
			if (reg_hit(i_sfr_rd, i_sfr_addr, `ADC_CONTROL_ADDR))
				o_sfr_rdata <= ctl_view;
			else if (reg_hit(i_sfr_rd, i_sfr_addr, `ADC_PRESCALE_ADDR))
				o_sfr_rdata <= {4'h0, refclk_enable_ff, refclk_div_ff};
			else if (reg_hit(i_sfr_rd, i_sfr_addr, `ADC_RESULT_LOW_ADDR))
				o_sfr_rdata <= result_low_ff;
			else if (reg_hit(i_sfr_rd, i_sfr_addr, `ADC_RESULT_HIGH_ADDR))
				o_sfr_rdata <= {6'h00, result_high_ff};
			else
				o_sfr_rdata <= 8'h00;
			o_conv_irq         <= conv_irq_flag_ff && conv_irq_enable_ff;
			o_converter_power  <= converter_enable_ff;
			o_converter_refclk <= ref_tick;
			// One mux input per code, gated by the pin's converter function
			o_analog_in        <= i_port1_pins[channel_select_ff] && pin_to_adc[channel_select_ff];
			o_calibrated       <= (cal_cnt_ff >= CAL_CYCLES);
			o_port1_gpio_mode  <= ~i_port1_func_select;
		end
	end

endmodule

`default_nettype wire

// ==== bench/sar_adc_props.sv ====
// Port-level checker of the converter controller.
// Assumes the controller's top ports only; bound at the foot.
`default_nettype none
module sar_adc_props #(parameter integer CAL_CYCLES = 20) (
	input wire logic       i_sys_clk,
	input wire logic       i_nrst,
	input wire logic [7:0] i_sfr_addr,
	input wire logic       i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic       i_sfr_rd,
	input wire logic [7:0] i_port1_func_select,
	input wire logic [7:0] i_port1_alt_select,
	input wire logic [7:0] i_port1_pins,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic       o_conv_irq,
	input wire logic       o_converter_power,
	input wire logic [9:0] o_dac_code,
	input wire logic       o_analog_in,
	input wire logic       o_calibrated,
	input wire logic [7:0] o_port1_gpio_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       ctl_we;
	logic       en_bit;
	logic [7:0] live;
	assign ctl_we = i_sfr_wr && i_sfr_addr == 8'h97;
	assign en_bit = i_sfr_wdata[5];
	assign live = i_port1_pins & i_port1_func_select & i_port1_alt_select;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	sequence start_wr; ctl_we && i_sfr_wdata[1]; endsequence
	sequence ctl_rd; i_sfr_rd && i_sfr_addr == 8'h97; endsequence
	AST_START_CLEAR: assert property (start_wr ##2 ctl_rd |=> !o_sfr_rdata[1])
		else $error("start bit not cleared");
	AST_HIGH_RSVD: assert property (i_sfr_rd && i_sfr_addr == 8'h96 |=> o_sfr_rdata[7:2] == 6'h00)
		else $error("reserved result bits set");
	AST_GPIO_MODE: assert property ($past(i_nrst) |-> o_port1_gpio_mode == ~$past(i_port1_func_select))
		else $error("pin mode wrong");
	AST_ANALOG_SRC: assert property ($past(i_nrst) && o_analog_in |-> |$past(live))
		else $error("converter input without live pin");
	AST_POWER: assert property (ctl_we ##1 !ctl_we |=> o_converter_power == $past(en_bit, 2))
		else $error("power does not follow enable");
	AST_DAC_IDLE: assert property (!o_converter_power [*2] |=> $stable(o_dac_code))
		else $error("trial code moves while off");
	AST_IRQ_HOLD: assert property (!ctl_we [*2] ##0 o_conv_irq |=> o_conv_irq)
		else $error("request dropped without software");
	AST_CAL: assert property ($rose(o_calibrated) |-> $past(o_converter_power, 8))
		else $error("calibrated too early");
endmodule
bind sar_adc_control sar_adc_props #(.CAL_CYCLES(CAL_CYCLES)) u_props (.i_sys_clk, .i_nrst, .i_sfr_addr,
	.i_sfr_wr, .i_sfr_wdata, .i_sfr_rd, .i_port1_func_select, .i_port1_alt_select, .i_port1_pins,
	.o_sfr_rdata, .o_conv_irq, .o_converter_power, .o_dac_code, .o_analog_in, .o_calibrated,
	.o_port1_gpio_mode);
`default_nettype wire

// ==== bench/sar_adc_far_side.sv ====
// Stand-in for the analog source and comparator of the converter core.
// Assumes the controller's trial code and a fixed input level.
`default_nettype none
module sar_adc_far_side (
	input  wire logic [9:0] i_dac_code,
	input  wire logic [9:0] i_level,
	output logic            o_cmp_high
);
	timeunit 1ns;
	timeprecision 1ns;
	// Keep the trial bit while the trial does not exceed the level
	assign o_cmp_high = (i_dac_code <= i_level);
endmodule
`default_nettype wire

// ==== bench/sar_adc_control_bench.sv ====
// Self-checking bench of the converter controller.
// Assumes the register header on the include path.
`include "sar_adc_regs.vh"
`default_nettype none
module sar_adc_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [9:0] LVL = 10'h2A5;
	logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, cmp, irq, pwr, rck, ain, cal;
	logic [7:0] addr = 8'h00, wd = 8'h00, fs = 8'h00, as = 8'h00, pins = 8'h00, rdat, gm, r;
	logic [9:0] dac;
	int         fails = 0, n_tests = 0, t0, t1, t2;
	sar_adc_control #(.CAL_CYCLES(20)) DUT (.i_sys_clk(clk), .i_nrst(nrst), .i_sfr_addr(addr),
		.i_sfr_wr(wr), .i_sfr_wdata(wd), .i_sfr_rd(rd), .i_port1_func_select(fs),
		.i_port1_alt_select(as), .i_port1_pins(pins), .i_cmp_high(cmp), .o_sfr_rdata(rdat),
		.o_conv_irq(irq), .o_converter_power(pwr), .o_converter_refclk(rck), .o_dac_code(dac),
		.o_analog_in(ain), .o_calibrated(cal), .o_port1_gpio_mode(gm));
	sar_adc_far_side far (.i_dac_code(dac), .i_level(LVL), .o_cmp_high(cmp));
	initial forever #10 clk = ~clk;
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			fails++;
			$display("ERROR at %0t: %s", $time, m);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wd = d;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		r = rdat;
		rd = 1'b0;
	endtask
	task automatic wait_hi(ref logic s, output int c);
		c = 0;
		while (s !== 1'b1) begin
			@(negedge clk);
			c++;
			if (c > 400) begin
				fails++;
				complete_run();
			end
		end
	endtask
	task automatic t_reset();
		for (int a = 'h93; a < 'h98; a++) begin
			rdr(8'(a));
			chk(r === 8'h00, "reset or unmapped value");
		end
		chk(gm === 8'hFF, "pins not general purpose");
		$display("reset test done");
	endtask
	task automatic t_route();
		fs = 8'hFF;
		as = 8'hFF;
		for (int c = 0; c < 8; c++) begin
			wrr(8'h97, 8'(c << 2));
			pins = 8'(1 << c);
			repeat (3) @(negedge clk);
			chk(ain === 1'b1 && gm === 8'h00, "channel not routed");
			pins = ~pins;
			repeat (3) @(negedge clk);
			chk(ain === 1'b0, "other channel routed");
		end
		pins = 8'hFF;
		fs = 8'h00;
		repeat (3) @(negedge clk);
		chk(ain === 1'b0 && gm === 8'hFF, "general pin feeds converter");
		$display("route test done");
	endtask
	task automatic t_conv(input logic [2:0] dv, output int c);
		int k;
		wrr(8'h97, 8'h00);
		wrr(8'h94, {5'h01, dv});
		wrr(8'h97, 8'h60);
		wait_hi(cal, c);
		chk(c >= 20 && c <= 22, "calibration time");
		wrr(8'h97, 8'h62);
		rdr(8'h97);
		chk(r[1] === 1'b0, "start bit stuck");
		chk(r[0] === 1'b0, "done set while converting");
		wait_hi(irq, c);
		rdr(8'h95);
		chk(r === LVL[7:0], "result low");
		rdr(8'h96);
		chk(r === {6'h00, LVL[9:8]}, "result high");
		rdr(8'h97);
		chk(r[7] === 1'b1, "flag not set");
		k = 0;
		repeat (8) begin
			@(negedge clk);
			if (rck === 1'b1)
				k++;
		end
		chk(k == (8 >> dv), "reference clock rate");
		$display("conversion test done");
	endtask
	task automatic t_more();
		wrr(8'h97, 8'h60);
		repeat (2) @(negedge clk);
		chk(irq === 1'b0, "request not cleared by software");
		wait_hi(irq, t0);
		chk(irq === 1'b1, "no repeat conversion");
		wrr(8'h97, 8'h20);
		repeat (60) @(negedge clk);
		rdr(8'h97);
		chk(irq === 1'b0 && r[7] === 1'b1, "masked request");
		wrr(8'h97, 8'hE0);
		repeat (2) @(negedge clk);
		chk(irq === 1'b1, "request not raised");
		wrr(8'h94, 8'h00);
		wrr(8'h97, 8'h60);
		repeat (60) @(negedge clk);
		chk(irq === 1'b0, "converts without reference clock");
		wrr(8'h97, 8'h00);
		repeat (8) @(negedge clk);
		chk(pwr === 1'b0, "still powered");
		$display("control test done");
	endtask
	initial begin
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		t_reset();
		t_route();
		wrr(8'h97, 8'h20);
		wait_hi(cal, t0);
		t_conv(3'h0, t0);
		t_conv(3'h1, t1);
		t_conv(3'h2, t2);
		chk(t0 == 11 && t1 >= 20 && t1 <= 21 && t2 >= 38 && t2 <= 41, "divider timing");
		t_more();
		complete_run();
	end
endmodule
`default_nettype wire
